// ==== logic/dtr_map.vh ====
`ifndef DTR_MAP_VH
`define DTR_MAP_VH

// Pin widths
`define DTR_AW          20
`define DTR_BAW         4
`define DTR_DQW         8
`define DTR_ROWW        2
`define DTR_NBANK       16

// Command encoding on {chip_sel_n, write_en_n, refresh_n}
`define DTR_CMD_MODE    3'h0
`define DTR_CMD_WRITE   3'h1
`define DTR_CMD_REFRESH 3'h2
`define DTR_CMD_READ    3'h3

// Mode word select on bank select lines 1:0 during a mode set
`define DTR_MW_FIRST    2'h0
`define DTR_MW_SECOND   2'h1
`define DTR_MW_THIRD    2'h2

// First mode word: data latency field
`define DTR_LAT_LSB     0
`define DTR_LAT_MSB     3
`define DTR_LAT_BASE    5'h03

// Second mode word fields
`define DTR_REF_PROTO_BIT 8
`define DTR_BL_LSB      9
`define DTR_BL_MSB      10

// Third mode word fields
`define DTR_TRN_EN_BIT  2
`define DTR_TRN_SEL_LSB 0
`define DTR_TRN_SEL_MSB 1
`define DTR_WP_LSB      3
`define DTR_WP_MSB      4

// Write protocol codes
`define DTR_WP_SINGLE   2'h0
`define DTR_WP_DUAL     2'h1
`define DTR_WP_QUAD     2'h2

// Burst length codes and last-beat indices
`define DTR_BL2_CODE    2'h0
`define DTR_BL4_CODE    2'h1
`define DTR_BL8_CODE    2'h2
`define DTR_TRN_LAST    3'h3

// Training pattern selects
`define DTR_PAT_ALL     2'h0
`define DTR_PAT_ALT     2'h1

// Limits
`define DTR_MAX_MULTI_REF 3'h4
`define DTR_FIFO_DEPTH  8

// Mode word reset values
`define DTR_MW_RESET    18'h00000

`endif

// ==== logic/dtr_sync2.v ====
`timescale 1ns/10ps
`default_nettype none

module dtr_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  // First stage is read only by the second
  reg [W-1:0] meta;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== logic/dtr_fifo.v ====
`timescale 1ns/10ps
`default_nettype none

module dtr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire push;
  wire pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    out_data = mem[rd_ptr];
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/dtr_device.v ====
`timescale 1ns/10ps
`default_nettype none
`include "dtr_map.vh"

// How it works
// R1: Training bit low gives array data; high gives the selected pattern on every read.
// R2: Controller idles all banks before the mode set that turns training on.
// R3: Each training read drives four pattern beats on all lines after read latency.
// R4: Training reads go to bank 0; address lines are ignored here.
// R5: Only reads while training; exit by mode set; reset still works.
// R6: Select 00 gives 0101 everywhere; 01 inverts odd lines.
// R7: Array contents may be lost in training; writes are not accepted then.
// R8: Third mode word bits 4:3 pick single, dual or quad bank writes.
// R9: Write beats taken on both write clock edges, from first rise after latency.
// R10: A beat with its mask high is dropped and the array keeps its old value.
// R11: Dual mode writes bank x and x+8, using bank bits 2:0 only.
// R12: Quad mode writes x, x+4, x+8, x+12, using bank bits 1:0.
// R13: Controller keeps at most 16 bank activations within any 8 ns.
// R14: Controller spaces quad writes two cycles from other bank commands.
// R15: Controller may add an idle cycle at write-read turnarounds.
// R16: Read data aligned to return clock; strobe leads half a clock, drops on last beat.
// R17: Outputs released after a burst; return clock keeps running; back-to-back reads gapless.
// R18: Single refresh mode refreshes the bank on the bank lines from an internal row count.
// R19: Multibank refresh takes address bits 15:0 as banks, at most four at once.
// R20: Controller waits the row cycle time before touching a refreshed bank.
// R21: Controller spaces three or four bank refreshes two cycles from bank commands.
// R22: Controller refreshes the whole device every 64 ms.
// R23: Second mode word bit 8 selects single or multibank refresh.
// R24: Controller keeps per-bank row cycle timers.
module dtr_device (
  input  wire                  clk,
  input  wire                  sys_rst,
  input  wire                  reset_pin_n,
  input  wire                  chip_sel_n,
  input  wire                  write_en_n,
  input  wire                  refresh_n,
  input  wire [`DTR_AW-1:0]    addr,
  input  wire [`DTR_BAW-1:0]   bank_sel,
  input  wire                  write_data_clock,
  input  wire [`DTR_DQW-1:0]   dq_in,
  input  wire                  write_mask,
  output reg  [`DTR_DQW-1:0]   dq_out,
  output reg                   dq_oe,
  output reg                   return_data_clock,
  output reg                   read_valid_strobe,
  output wire                  write_fifo_ready,
  output reg                   write_dropped,
  output reg  [`DTR_NBANK-1:0] refreshed_banks,
  output wire                  training_active
);

  localparam PIPE = 32;

  reg [17:0] first_mode_word;
  reg [17:0] second_mode_word;
  reg [17:0] third_mode_word;
  reg [7:0]  mem [0:511];
  reg [1:0]  ref_row [0:`DTR_NBANK-1];

  wire       pin_rst_n;
  wire [8:0] wr_pins;
  wire       wclk_s;
  reg        wclk_d;

  dtr_sync2 #(.W(1)) u_rst_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (reset_pin_n),
    .sync_out (pin_rst_n)
  );

  // Data, mask and strobe clock share one delay so their alignment holds
  dtr_sync2 #(.W(10)) u_wr_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({write_data_clock, write_mask, dq_in}),
    .sync_out ({wclk_s, wr_pins})
  );

  function [15:0] bank_set;
    input [1:0] proto;
    input [3:0] ba;
    reg   [15:0] s;
    begin
      s = 16'h0000;
      case (proto)
        `DTR_WP_DUAL: begin
          s[{1'b0, ba[2:0]}] = 1'b1;
          s[{1'b1, ba[2:0]}] = 1'b1;
        end
        `DTR_WP_QUAD: begin
          s[{2'h0, ba[1:0]}] = 1'b1;
          s[{2'h1, ba[1:0]}] = 1'b1;
          s[{2'h2, ba[1:0]}] = 1'b1;
          s[{2'h3, ba[1:0]}] = 1'b1;
        end
        default: begin
          s[ba] = 1'b1;
        end
      endcase
      bank_set = s;
    end
  endfunction

  function [2:0] last_beat;
    input [1:0] code;
    begin
      case (code)
        `DTR_BL4_CODE: last_beat = 3'h3;
        `DTR_BL8_CODE: last_beat = 3'h7;
        default:       last_beat = 3'h1;
      endcase
    end
  endfunction

  function [2:0] ones16;
    input [15:0] v;
    integer i;
    reg [4:0] n;
    begin
      n = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        n = n + {4'h0, v[i]};
      end
      ones16 = (n > 5'h04) ? 3'h7 : n[2:0];
    end
  endfunction

  function [`DTR_DQW-1:0] pattern;
    input [1:0] sel;
    input [2:0] beat;
    integer j;
    begin
      for (j = 0; j < `DTR_DQW; j = j + 1) begin
        if (sel == `DTR_PAT_ALT && j[0]) begin
          pattern[j] = ~beat[0];
        end else begin
          pattern[j] = beat[0];
        end
      end
    end
  endfunction

  wire [2:0] cmd = {chip_sel_n, write_en_n, refresh_n};
  wire       cmd_mode    = (cmd == `DTR_CMD_MODE);
  wire       cmd_write   = (cmd == `DTR_CMD_WRITE);
  wire       cmd_refresh = (cmd == `DTR_CMD_REFRESH);
  wire       cmd_read    = (cmd == `DTR_CMD_READ);

  wire       trn_en  = third_mode_word[`DTR_TRN_EN_BIT];
  wire [1:0] trn_sel = third_mode_word[`DTR_TRN_SEL_MSB:`DTR_TRN_SEL_LSB];
  wire [1:0] wproto  = third_mode_word[`DTR_WP_MSB:`DTR_WP_LSB];
  wire       multi_ref = second_mode_word[`DTR_REF_PROTO_BIT];
  wire [2:0] bl_last = last_beat(second_mode_word[`DTR_BL_MSB:`DTR_BL_LSB]);
  wire [4:0] lat = `DTR_LAT_BASE + {1'b0, first_mode_word[`DTR_LAT_MSB:`DTR_LAT_LSB]};

  assign training_active = trn_en;

  // Mode words; the pin reset returns them to defaults
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_mode_word  <= `DTR_MW_RESET;
      second_mode_word <= `DTR_MW_RESET;
      third_mode_word  <= `DTR_MW_RESET;
    end else if (!pin_rst_n) begin
      first_mode_word  <= `DTR_MW_RESET;
      second_mode_word <= `DTR_MW_RESET;
      third_mode_word  <= `DTR_MW_RESET;
    end else if (cmd_mode) begin
      case (bank_sel[1:0])
        `DTR_MW_FIRST:  first_mode_word  <= addr[17:0];
        `DTR_MW_SECOND: second_mode_word <= addr[17:0]; // R23
        `DTR_MW_THIRD:  third_mode_word  <= addr[17:0]; // R5
        default: begin
        end
      endcase
    end
  end

  // Read latency pipeline: one slot per cycle
  reg [PIPE-1:0]      rd_pipe;
  reg [`DTR_BAW-1:0]  rd_bank_p [0:PIPE-1];
  reg [1:0]           rd_row_p  [0:PIPE-1];
  reg                 rd_trn_p  [0:PIPE-1];
  integer             k;
  wire [4:0]          tap  = lat - 5'h02;
  wire                launch = rd_pipe[tap];

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pipe <= {PIPE{1'b0}};
    end else if (!pin_rst_n) begin
      rd_pipe <= {PIPE{1'b0}};
    end else begin
      rd_pipe <= {rd_pipe[PIPE-2:0], cmd_read};
    end
  end

  always @(posedge clk) begin
    rd_bank_p[0] <= trn_en ? {`DTR_BAW{1'b0}} : bank_sel; // R4
    rd_row_p[0]  <= addr[1:0];
    rd_trn_p[0]  <= trn_en;
    for (k = 1; k < PIPE; k = k + 1) begin
      rd_bank_p[k] <= rd_bank_p[k-1];
      rd_row_p[k]  <= rd_row_p[k-1];
      rd_trn_p[k]  <= rd_trn_p[k-1];
    end
  end

  // Read burst engine; a pre during the last beat chains seamlessly
  reg                burst_on;
  reg                pre;
  reg [2:0]          beat;
  reg [2:0]          cur_last;
  reg [`DTR_BAW-1:0] cur_bank;
  reg [1:0]          cur_row;
  reg                cur_trn;
  reg [`DTR_BAW-1:0] nxt_bank;
  reg [1:0]          nxt_row;
  reg                nxt_trn;
  wire               burst_end = burst_on & (beat == cur_last);
  wire [`DTR_DQW-1:0] rd_word = mem[{cur_bank, cur_row, beat}];

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      return_data_clock <= 1'b0;
      read_valid_strobe <= 1'b0;
      dq_out   <= {`DTR_DQW{1'b0}};
      dq_oe    <= 1'b0;
      burst_on <= 1'b0;
      pre      <= 1'b0;
      beat     <= 3'h0;
      cur_last <= 3'h1;
      cur_bank <= {`DTR_BAW{1'b0}};
      cur_row  <= 2'h0;
      cur_trn  <= 1'b0;
      nxt_bank <= {`DTR_BAW{1'b0}};
      nxt_row  <= 2'h0;
      nxt_trn  <= 1'b0;
    end else begin
      // Return clock free-runs through reset pin activity too
      return_data_clock <= ~return_data_clock; // R17
      if (!pin_rst_n) begin
        burst_on <= 1'b0;
        pre      <= 1'b0;
        dq_oe    <= 1'b0;
        read_valid_strobe <= 1'b0;
      end else begin
        pre <= launch;
        if (launch) begin
          nxt_bank <= rd_bank_p[tap];
          nxt_row  <= rd_row_p[tap];
          nxt_trn  <= rd_trn_p[tap];
        end
        // Strobe rises one cycle (half return clock) before the first beat
        // and drops as the last beat goes out; a chained pre keeps it high
        read_valid_strobe <= pre | (burst_on & (beat < cur_last)); // R16
        if (pre) begin
          burst_on <= 1'b1;
          beat     <= 3'h0;
          cur_bank <= nxt_bank;
          cur_row  <= nxt_row;
          cur_trn  <= nxt_trn;
          cur_last <= nxt_trn ? `DTR_TRN_LAST : bl_last; // R3
        end else if (burst_end) begin
          burst_on <= 1'b0;
        end else if (burst_on) begin
          beat <= beat + 3'h1;
        end
        if (burst_on) begin
          dq_oe  <= 1'b1;
          dq_out <= cur_trn ? pattern(trn_sel, beat) : rd_word; // R1 R6
        end else begin
          dq_oe <= 1'b0; // R17
        end
      end
    end
  end

  // Write launch and capture on synchronised write clock edges
  reg        wclk_rise;
  reg        wpend;
  reg [4:0]  wcnt;
  reg        capturing;
  reg [2:0]  wbeat;
  reg [2:0]  wlast;
  reg [15:0] wset;
  reg [1:0]  wrow;
  reg        push;
  reg [28:0] push_data;
  wire       wedge = wclk_s ^ wclk_d;
  wire       fifo_valid;
  wire [28:0] fifo_data;

  always @* begin
    wclk_rise = wclk_s & ~wclk_d;
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wclk_d        <= 1'b0;
      wpend         <= 1'b0;
      wcnt          <= 5'h00;
      capturing     <= 1'b0;
      wbeat         <= 3'h0;
      wlast         <= 3'h1;
      wset          <= 16'h0000;
      wrow          <= 2'h0;
      push          <= 1'b0;
      push_data     <= 29'h00000000;
      write_dropped <= 1'b0;
    end else begin
      wclk_d <= wclk_s;
      push   <= 1'b0;
      write_dropped <= push & ~write_fifo_ready;
      if (!pin_rst_n) begin
        wpend     <= 1'b0;
        capturing <= 1'b0;
      end else begin
        if (cmd_write && !trn_en) begin // R7
          wpend <= 1'b1;
          wcnt  <= lat;
          wset  <= bank_set(wproto, bank_sel); // R8 R11 R12
          wrow  <= addr[1:0];
          wlast <= bl_last;
        end else if (wpend && wcnt != 5'h00) begin
          wcnt <= wcnt - 5'h01;
        end
        if (wpend && wcnt == 5'h00 && wclk_rise && !capturing) begin // R9
          wpend     <= 1'b0;
          capturing <= 1'b1;
          wbeat     <= 3'h1;
          push      <= ~wr_pins[8]; // R10
          push_data <= {wset, wrow, 3'h0, wr_pins[7:0]};
        end else if (capturing && wedge) begin
          push      <= ~wr_pins[8]; // R10
          push_data <= {push_data[28:11], wbeat, wr_pins[7:0]};
          wbeat     <= wbeat + 3'h1;
          if (wbeat == wlast) begin
            capturing <= 1'b0;
          end
        end
      end
    end
  end

  // Drain stalls while a refresh owns the array, so the FIFO can fill
  wire drain = fifo_valid & ~cmd_refresh;

  dtr_fifo #(.WIDTH(29), .DEPTH(`DTR_FIFO_DEPTH), .AW(3)) u_wfifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (write_fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (~cmd_refresh),
    .out_data  (fifo_data)
  );

  integer b;
  always @(posedge clk) begin
    if (drain) begin
      for (b = 0; b < `DTR_NBANK; b = b + 1) begin
        if (fifo_data[13+b]) begin
          mem[{b[3:0], fifo_data[12:11], fifo_data[10:8]}] <= fifo_data[7:0]; // R11 R12
        end
      end
    end
  end

  // Refresh: bank lines or address bitmap; rows from internal counters
  wire [15:0] ref_set = multi_ref ? addr[15:0] : bank_set(`DTR_WP_SINGLE, bank_sel); // R18 R19
  wire        ref_ok  = ~multi_ref | (ones16(addr[15:0]) <= `DTR_MAX_MULTI_REF); // R19
  integer r;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refreshed_banks <= 16'h0000;
      for (r = 0; r < `DTR_NBANK; r = r + 1) begin
        ref_row[r] <= 2'h0;
      end
    end else if (!pin_rst_n) begin
      refreshed_banks <= 16'h0000;
    end else begin
      refreshed_banks <= 16'h0000;
      if (cmd_refresh && ref_ok && !trn_en) begin
        refreshed_banks <= ref_set; // R18 R19
        for (r = 0; r < `DTR_NBANK; r = r + 1) begin
          if (ref_set[r]) begin
            ref_row[r] <= ref_row[r] + 2'h1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/dtr_unused_placeholder.v ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== bench/dtr_ctl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dtr_map.vh"
module dtr_ctl_model #(
  parameter MIN_GAP = 2
) (
  input  wire                 clk,
  output logic                reset_pin_n,
  output logic                chip_sel_n,
  output logic                write_en_n,
  output logic                refresh_n,
  output logic [`DTR_AW-1:0]  addr,
  output logic [`DTR_BAW-1:0] bank_sel,
  output logic                write_data_clock,
  output logic [`DTR_DQW-1:0] dq_in,
  output logic                write_mask
);
  initial begin
    reset_pin_n = 1'b1;
    {chip_sel_n, write_en_n, refresh_n} = 3'h7;
    addr = 20'h00000;
    bank_sel = 4'h0;
    write_data_clock = 1'b0;
    dq_in = 8'h00;
    write_mask = 1'b0;
  end
  // Every command is followed by MIN_GAP idle cycles at least, which covers
  // the quad write and big refresh spacing and any bus turnaround
  task cmd(input [2:0] c, input [3:0] ba, input [19:0] a, input int gap);
    begin
      @(posedge clk);
      {chip_sel_n, write_en_n, refresh_n} <= c;
      bank_sel <= ba;
      addr <= a;
      @(posedge clk);
      chip_sel_n <= 1'b1;
      bank_sel <= ~ba;
      addr <= ~a;
      repeat ((gap > MIN_GAP ? gap : MIN_GAP) - 1) @(posedge clk);
    end
  endtask
  // Write clock runs only within a burst; lines show the inverse once released
  task wr(input [3:0] ba, input [31:0] d, input [3:0] m);
    int i;
    begin
      cmd(`DTR_CMD_WRITE, ba, 20'h00001, MIN_GAP);
      for (i = 0; i < 4; i++) begin
        dq_in <= d[8*i +: 8];
        write_mask <= m[i];
        repeat (4) @(posedge clk);
        write_data_clock <= ~write_data_clock;
        repeat (4) @(posedge clk);
      end
      dq_in <= ~d[31:24];
      write_mask <= ~m[3];
      repeat (16) @(posedge clk);
    end
  endtask
  // Run is far shorter than one refresh period, so no schedule is kept
  task pin_reset;
    begin
      @(posedge clk);
      reset_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/dtr_device_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dtr_map.vh"
module dtr_device_chk (
  input wire                  clk,
  input wire                  sys_rst,
  input wire                  reset_pin_n,
  input wire                  chip_sel_n,
  input wire                  write_en_n,
  input wire                  refresh_n,
  input wire [`DTR_AW-1:0]    addr,
  input wire [`DTR_BAW-1:0]   bank_sel,
  input wire                  dq_oe,
  input wire                  return_data_clock,
  input wire                  read_valid_strobe,
  input wire [`DTR_NBANK-1:0] refreshed_banks,
  input wire                  training_active
);
  wire [2:0] cmd = {chip_sel_n, write_en_n, refresh_n};
  reg  [3:0] lat;
  reg  [1:0] blc;
  reg        proto;
  // Cleared at once on the pin, ahead of the device; no command comes then
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lat   <= 4'h0;
      blc   <= 2'h0;
      proto <= 1'b0;
    end else if (!reset_pin_n) begin
      lat   <= 4'h0;
      blc   <= 2'h0;
      proto <= 1'b0;
    end else if (cmd == `DTR_CMD_MODE && bank_sel[1:0] == `DTR_MW_FIRST) begin
      lat <= addr[`DTR_LAT_MSB:`DTR_LAT_LSB];
    end else if (cmd == `DTR_CMD_MODE && bank_sel[1:0] == `DTR_MW_SECOND) begin
      blc   <= addr[`DTR_BL_MSB:`DTR_BL_LSB];
      proto <= addr[`DTR_REF_PROTO_BIT];
    end
  end
  wire rd = cmd == `DTR_CMD_READ && lat == 4'h0 && (blc == `DTR_BL4_CODE || training_active);
  wire rf = cmd == `DTR_CMD_REFRESH && !training_active;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_rd_lead;
    rd |-> ##4 read_valid_strobe;
  endproperty
  a_rd_lead: assert property (p_rd_lead) else $error("strobe late");
  property p_rd_burst;
    rd |-> ##5 dq_oe [*4];
  endproperty
  a_rd_burst: assert property (p_rd_burst) else $error("burst short");
  property p_oe_after;
    $fell(read_valid_strobe) |-> dq_oe ##1 !dq_oe;
  endproperty
  a_oe_after: assert property (p_oe_after) else $error("strobe not on last beat");
  property p_oe_lead;
    $rose(dq_oe) |-> $past(read_valid_strobe) && read_valid_strobe;
  endproperty
  a_oe_lead: assert property (p_oe_lead) else $error("strobe not ahead of data");
  property p_oe_end;
    $fell(dq_oe) |-> !$past(read_valid_strobe);
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("strobe held past burst");
  property p_trn_flag;
    cmd == `DTR_CMD_MODE && bank_sel[1:0] == `DTR_MW_THIRD && reset_pin_n
      |=> training_active == $past(addr[`DTR_TRN_EN_BIT]);
  endproperty
  a_trn_flag: assert property (p_trn_flag) else $error("training flag wrong");
  property p_trn_ref;
    training_active && cmd == `DTR_CMD_REFRESH |=> refreshed_banks == 16'h0000;
  endproperty
  a_trn_ref: assert property (p_trn_ref) else $error("refresh taken in training");
  property p_ref_one;
    rf && !proto |=> refreshed_banks == 16'h0001 << $past(bank_sel);
  endproperty
  a_ref_one: assert property (p_ref_one) else $error("single refresh bank wrong");
  property p_ref_multi;
    rf && proto |=> refreshed_banks ==
      ($countones($past(addr[15:0])) > 4 ? 16'h0000 : $past(addr[15:0]));
  endproperty
  a_ref_multi: assert property (p_ref_multi) else $error("multibank refresh wrong");
  property p_ref_pulse;
    refreshed_banks != 16'h0000 && cmd != `DTR_CMD_REFRESH |=> refreshed_banks == 16'h0000;
  endproperty
  a_ref_pulse: assert property (p_ref_pulse) else $error("refresh pulse stuck");
  property p_qk;
    !$past(sys_rst) |-> return_data_clock != $past(return_data_clock);
  endproperty
  a_qk: assert property (p_qk) else $error("return clock stopped");
endmodule
bind dtr_device dtr_device_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .chip_sel_n(chip_sel_n),
  .write_en_n(write_en_n), .refresh_n(refresh_n), .addr(addr), .bank_sel(bank_sel),
  .dq_oe(dq_oe), .return_data_clock(return_data_clock),
  .read_valid_strobe(read_valid_strobe), .refreshed_banks(refreshed_banks),
  .training_active(training_active)
);
`default_nettype wire

// ==== bench/dtr_device_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dtr_map.vh"
module dtr_device_tb;
  logic        clk;
  logic        sys_rst;
  wire         reset_pin_n, chip_sel_n, write_en_n, refresh_n;
  wire [19:0]  addr;
  wire [3:0]   bank_sel;
  wire         write_data_clock, write_mask, dq_oe, return_data_clock;
  wire         read_valid_strobe, training_active;
  wire [7:0]   dq_in, dq_out;
  wire [15:0]  refreshed_banks;
  wire         write_fifo_ready, write_dropped;
  logic        drops;
  logic [7:0]  rq[$];
  logic [15:0] refacc;
  int          bad_count, checked, run, maxrun, i;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dtr_device DUT (
    .clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .chip_sel_n(chip_sel_n),
    .write_en_n(write_en_n), .refresh_n(refresh_n), .addr(addr), .bank_sel(bank_sel),
    .write_data_clock(write_data_clock), .dq_in(dq_in), .write_mask(write_mask),
    .dq_out(dq_out), .dq_oe(dq_oe), .return_data_clock(return_data_clock),
    .read_valid_strobe(read_valid_strobe), .write_fifo_ready(write_fifo_ready),
    .write_dropped(write_dropped),
    .refreshed_banks(refreshed_banks), .training_active(training_active)
  );
  dtr_ctl_model ctl (
    .clk(clk), .reset_pin_n(reset_pin_n), .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
    .refresh_n(refresh_n), .addr(addr), .bank_sel(bank_sel), .dq_in(dq_in),
    .write_data_clock(write_data_clock), .write_mask(write_mask)
  );
  always @(posedge clk) begin
    if (dq_oe === 1'b1) begin
      rq.push_back(dq_out);
      run = run + 1;
    end else begin
      run = 0;
    end
    if (run > maxrun) maxrun = run;
    refacc = refacc | refreshed_banks;
    drops = drops | write_dropped;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task ms(input [1:0] w, input [19:0] v);
    ctl.cmd(`DTR_CMD_MODE, {2'h0, w}, v, 2);
  endtask
  task rd(input [3:0] ba, input [31:0] e);
    begin
      #1;
      rq.delete();
      ctl.cmd(`DTR_CMD_READ, ba, 20'h00001, 2);
      repeat (12) @(posedge clk);
      chk(rq.size(), 4);
      chk({rq[3], rq[2], rq[1], rq[0]}, e);
    end
  endtask
  task refchk(input [3:0] ba, input [19:0] a, input [15:0] e);
    begin
      #1;
      refacc = 16'h0000;
      ctl.cmd(`DTR_CMD_REFRESH, ba, a, 2);
      repeat (3) @(posedge clk);
      chk(refacc, e);
    end
  endtask
  task print_verdict;
    begin
      if (bad_count == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    drops = 1'b0;
    refacc = 16'h0000;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    ms(`DTR_MW_FIRST, 20'h00000);
    ms(`DTR_MW_SECOND, 20'h00200);
    ms(`DTR_MW_THIRD, 20'h00008);
    ctl.wr(4'h9, 32'h3C5AA5C3, 4'h0);
    chk(drops, 0);
    rd(4'h1, 32'h3C5AA5C3);
    rd(4'h9, 32'h3C5AA5C3);
    ms(`DTR_MW_THIRD, 20'h00010);
    ctl.wr(4'hE, 32'h0FF01E2D, 4'h0);
    #1;
    rq.delete();
    maxrun = 0;
    ctl.cmd(`DTR_CMD_READ, 4'h2, 20'h00001, 3);
    ctl.cmd(`DTR_CMD_READ, 4'h6, 20'h00001, 2);
    repeat (14) @(posedge clk);
    chk(maxrun, 8);
    chk({rq[3], rq[2], rq[1], rq[0]}, 32'h0FF01E2D);
    chk({rq[7], rq[6], rq[5], rq[4]}, 32'h0FF01E2D);
    rd(4'hA, 32'h0FF01E2D);
    ms(`DTR_MW_THIRD, 20'h00000);
    ctl.wr(4'h1, 32'h44332211, 4'h4);
    rd(4'h1, 32'h445A2211);
    rd(4'h9, 32'h3C5AA5C3);
    refchk(4'h5, 20'hFFFFF, 16'h0020);
    ms(`DTR_MW_SECOND, 20'h00300);
    refchk(4'hF, 20'h08421, 16'h8421);
    refchk(4'h3, 20'h0001F, 16'h0000);
    // Nothing stored earlier is read back after training starts
    ms(`DTR_MW_THIRD, 20'h00004);
    chk(training_active, 1);
    rd(4'h0, 32'hFF00FF00);
    refchk(4'h0, 20'h00001, 16'h0000);
    ms(`DTR_MW_THIRD, 20'h00005);
    rd(4'h0, 32'h55AA55AA);
    ctl.pin_reset();
    chk(training_active, 0);
    chk(write_fifo_ready, 1);
    chk(drops, 0);
    print_verdict;
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    print_verdict;
  end
endmodule
`default_nettype wire
